// ### sim/host_error_status_bank_test.sv
// Self-checking bench for the host error status bank
`timescale 1ns/10ps
module host_error_status_bank_test;
    import host_err_pkg::*;

    logic           clk;
    logic           rst_n;
    reg_req_s       reg_req;
    logic [7:0]     reg_rdata;
    logic           reg_rvalid;
    sleep_state_e   sleep_state;
    logic [39:0]    sleep_mask_s3;
    logic [39:0]    sleep_mask_s45;
    logic           legacy_regulator_vid_mode;
    raw_event_s     raw_event;
    throttle_meas_s throttle_meas;
    logic [39:0]    status_bank;
    logic           host_summary_flag;
    int             err_total;
    int             checked;

    localparam logic [29:0] raw_idle    = 30'h100_0000;
    localparam logic [39:0] always_mask = 40'hFF_3C_47_FF_30;
    localparam logic [39:0] option_mask = 40'h00_C3_38_00_03;

    host_error_status_bank i_dut (
        .clk                       (clk),
        .rst_n                     (rst_n),
        .reg_req                   (reg_req),
        .reg_rdata                 (reg_rdata),
        .reg_rvalid                (reg_rvalid),
        .sleep_state               (sleep_state),
        .sleep_mask_s3             (sleep_mask_s3),
        .sleep_mask_s45            (sleep_mask_s45),
        .legacy_regulator_vid_mode (legacy_regulator_vid_mode),
        .raw_event                 (raw_event),
        .throttle_meas             (throttle_meas),
        .status_bank               (status_bank),
        .host_summary_flag         (host_summary_flag)
    );

    host_sw_model i_host (
        .clk        (clk),
        .reg_req    (reg_req),
        .reg_rdata  (reg_rdata),
        .reg_rvalid (reg_rvalid)
    );

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [39:0] seen,
                         input logic [39:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic final_report;
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Raw event bit to bank bit
    function automatic int bank_bit(input int i);
        if (i >= 26) return i - 26;
        if (i >= 24) return 29 - i;
        if (i >= 8) return i;
        if (i >= 6) return 31 - i;
        if (i >= 4) return 35 - i;
        return 29 - i;
    endfunction

    task automatic reg_check(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic       ok;
        i_host.read_reg(a, d, ok);
        check("rvalid", {39'h0, ok}, 40'h1);
        check("rdata", {32'h0, d}, {32'h0, exp});
    endtask

    task automatic pulse_event(input logic [29:0] r);
        @(posedge clk);
        raw_event <= r;
        @(posedge clk);
        raw_event <= raw_idle;
        @(negedge clk);
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        check("bank", status_bank, 40'h0);
        check("summary", 40'(host_summary_flag), 40'h0);
        for (int a = 8'h48; a <= 8'h4D; a++) begin
            reg_check(a[7:0], 8'h00);
        end
        $display("test reset done");
    endtask

    task automatic t_sticky;
        @(posedge clk);
        raw_event <= raw_idle ^ 30'h1000_0000;
        @(negedge clk);
        @(negedge clk);
        check("set", status_bank, 40'h04);
        check("summary", 40'(host_summary_flag), 40'h1);
        i_host.write_reg(8'h48, 8'h04);
        @(negedge clk);
        check("busy clear", status_bank, 40'h04);
        @(posedge clk);
        raw_event <= raw_idle;
        @(negedge clk);
        @(negedge clk);
        check("held", status_bank, 40'h04);
        i_host.write_reg(8'h48, 8'hFB);
        reg_check(8'h48, 8'h04);
        i_host.write_reg(8'h4D, 8'hFF);
        reg_check(8'h48, 8'h04);
        i_host.write_reg(8'h48, 8'h04);
        @(negedge clk);
        check("cleared", status_bank, 40'h0);
        check("summary", 40'(host_summary_flag), 40'h0);
        $display("test sticky done");
    endtask

    task automatic t_walk(input sleep_state_e st, input logic [39:0] m);
        logic [39:0] hide;
        logic [39:0] exp;
        logic [7:0]  ofs;
        int          b;
        hide = 40'h0;
        if (st == SLEEP_S3 || st == SLEEP_S45) begin
            hide = always_mask | (option_mask & m);
        end
        @(posedge clk);
        sleep_state    <= st;
        sleep_mask_s3  <= (st == SLEEP_S45) ? ~m : m;
        sleep_mask_s45 <= (st == SLEEP_S3) ? ~m : m;
        for (int i = 0; i < 30; i++) begin
            b   = bank_bit(i);
            exp = (40'h1 << b) & ~hide;
            ofs = 8'h48 + 8'(b / 8);
            pulse_event(raw_idle ^ (30'h1 << i));
            check("event", status_bank, exp);
            check("summary", 40'(host_summary_flag), 40'(|exp));
            reg_check(ofs, 8'(exp >> (8 * (b / 8))));
            i_host.write_reg(ofs, 8'h1 << (b % 8));
            @(negedge clk);
            check("cleared", status_bank, 40'h0);
        end
        $display("test walk %0d done", st);
    endtask

    task automatic t_legacy;
        @(posedge clk);
        legacy_regulator_vid_mode <= 1'b0;
        pulse_event(raw_idle ^ 30'h00C);
        check("fuse off", status_bank, 40'h0);
        @(posedge clk);
        legacy_regulator_vid_mode <= 1'b1;
        $display("test legacy done");
    endtask

    task automatic t_throttle;
        logic [8:0] duty [13] = '{9'h000, 9'h001, 9'h01F, 9'h020, 9'h03F,
            9'h040, 9'h07F, 9'h080, 9'h0BF, 9'h0C0, 9'h0FF, 9'h100, 9'h100};
        logic [7:0] exp;
        int         bin;
        for (int i = 0; i < 13; i++) begin
            bin = duty[i] < 9'h020 ? 1 : duty[i] < 9'h040 ? 2 :
                  duty[i] < 9'h080 ? 3 : duty[i] < 9'h0C0 ? 4 :
                  duty[i] < 9'h100 ? 5 : 6;
            exp = (8'h1 << bin) | {duty[i] > 9'h0C0, 6'h0, duty[i] != 9'h0};
            if (i == 12) exp = 8'h00;
            @(posedge clk);
            if (i == 12) sleep_state <= SLEEP_S3;
            throttle_meas <= {duty[i] != 9'h0, 1'b1, duty[i], 9'h0C0};
            @(posedge clk);
            throttle_meas <= {2'b00, duty[i], 9'h0C0};
            @(negedge clk);
            check("throttle", 40'(status_bank[39:32]), 40'(exp));
            check("summary", 40'(host_summary_flag), 40'(exp[7]));
            reg_check(8'h4C, exp);
            i_host.write_reg(8'h4C, 8'hFF);
        end
        @(posedge clk);
        sleep_state <= SLEEP_S0;
        $display("test throttle done");
    endtask

    task automatic t_midreset;
        pulse_event(raw_idle ^ 30'h400_0000);
        check("zone one", status_bank, 40'h1);
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        check("reset", status_bank, 40'h0);
        check("summary", 40'(host_summary_flag), 40'h0);
        reg_check(8'h48, 8'h00);
        $display("test midreset done");
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        rst_n                     = 1'b0;
        sleep_state               = SLEEP_S0;
        sleep_mask_s3             = 40'h0;
        sleep_mask_s45            = 40'h0;
        legacy_regulator_vid_mode = 1'b1;
        raw_event                 = raw_idle;
        throttle_meas             = '0;
        err_total                 = 0;
        checked                   = 0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        t_reset;
        t_sticky;
        t_walk(SLEEP_S0, '1);
        t_walk(SLEEP_S1, '1);
        t_walk(SLEEP_S3, '0);
        t_walk(SLEEP_S3, '1);
        t_walk(SLEEP_S45, '0);
        t_walk(SLEEP_S45, '1);
        t_walk(SLEEP_S0, '0);
        t_legacy;
        t_throttle;
        t_midreset;
        final_report;
    end

    // Watchdog against a hang
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        $display("watchdog expired");
        final_report;
    end
endmodule // host_error_status_bank_test

// ### sim/host_sw_model.sv
// Host software model issuing register reads and writes
`timescale 1ns/10ps
module host_sw_model (
    input  wire logic              clk,
    output host_err_pkg::reg_req_s reg_req,
    input  wire logic [7:0]        reg_rdata,
    input  wire logic              reg_rvalid
);
    import host_err_pkg::*;

    initial begin
        reg_req = '0;
    end

    ////////////////////////////////////////////////////////////////////////
    // ones clear bits
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_req.wr    <= 1'b1;
        reg_req.addr  <= a;
        reg_req.wdata <= d;
        @(posedge clk);
        reg_req.wr    <= 1'b0;
        reg_req.addr  <= ~a;
        reg_req.wdata <= ~d;
    endtask

    // Released address shows its inverse
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d,
                            output logic ok);
        @(posedge clk);
        reg_req.rd   <= 1'b1;
        reg_req.addr <= a;
        @(posedge clk);
        reg_req.rd   <= 1'b0;
        reg_req.addr <= ~a;
        @(negedge clk);
        d  = reg_rdata;
        ok = reg_rvalid;
    endtask
endmodule // host_sw_model

// ### src/host_err_defs.svh
// Offsets, field layout, reset values and thresholds of the host error bank
`ifndef HOST_ERR_DEFS_SVH
`define HOST_ERR_DEFS_SVH

// Register offsets on the register port
`define HEB_OFS_TEMP_VRD      8'h48
`define HEB_OFS_ANALOG_LOW    8'h49
`define HEB_OFS_ANALOG_HIGH   8'h4A
`define HEB_OFS_DIODE_FUSE    8'h4B
`define HEB_OFS_CPU1_THROTTLE 8'h4C

// Reset value of every status register
`define HEB_RESET_BYTE        8'h00
`define HEB_RESET_BANK        40'h00_00_00_00_00

// Bank layout {4Ch, 4Bh, 4Ah, 49h, 48h}; implemented bits
`define HEB_IMPL_BITS         40'hFF_FF_FF_FF_3F
// Masked in S3 and S45 without option
`define HEB_ALWAYS_MASK       40'hFF_3C_47_FF_30
// Masked in sleep only when the sleep-state mask asks for it
`define HEB_OPTION_MASK       40'h00_C3_38_00_03
// Bits feeding the summary flag; throttle bins excluded
`define HEB_SUMMARY_BITS      40'h80_FF_FF_FF_3F

// Field positions inside the bank vector
`define HEB_BIT_ZONE_ONE      0
`define HEB_BIT_ZONE_THREE    2
`define HEB_BIT_REG_ONE_HOT   4
`define HEB_BIT_CH16          23
`define HEB_BIT_FUSE_EIGHT    26
`define HEB_BIT_THR_ANY       32
`define HEB_BIT_THR_FULL      38
`define HEB_BIT_THR_LIMIT     39

// Throttle duty thresholds in 1/256 units
`define HEB_DUTY_EIGHTH       9'h020
`define HEB_DUTY_QUARTER      9'h040
`define HEB_DUTY_HALF         9'h080
`define HEB_DUTY_THREE_Q      9'h0C0
`define HEB_DUTY_FULL         9'h100

`endif

// ### src/host_err_pkg.sv
// Types shared by the host error status bank
package host_err_pkg;

    // Sleep state as stored by software elsewhere
    typedef enum logic [1:0] {
        SLEEP_S0  = 2'b00,
        SLEEP_S1  = 2'b01,
        SLEEP_S3  = 2'b10,
        SLEEP_S45 = 2'b11
    } sleep_state_e;

    // Register port request
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_s;

    // Raw error conditions from the limit comparators
    typedef struct packed {
        logic [3:0]  zone_limit;
        logic        regulator_one_hot_in;
        logic        regulator_two_hot_in_n;
        logic [15:0] analog_channel_n;
        logic        remote_diode_1b_fault;
        logic        remote_diode_2b_fault;
        logic        remote_diode_1a_fault;
        logic        remote_diode_2a_fault;
        logic        fuse_monitor_in_eight;
        logic        fuse_monitor_in_nine;
        logic        core_supply_one_mismatch;
        logic        core_supply_two_mismatch;
    } raw_event_s;

    // Throttle measurement of processor one
    typedef struct packed {
        logic       cpu1_throttle_in;
        logic       duty_valid;
        logic [8:0] duty;
        logic [8:0] limit;
    } throttle_meas_s;

endpackage

// ### src/host_error_status_bank.sv
// Sticky write-one-to-clear host error status bank with sleep masking
`timescale 1ns/10ps
`include "host_err_defs.svh"

module host_error_status_bank (
    input  wire logic                         clk,
    input  wire logic                         rst_n,
    input  wire host_err_pkg::reg_req_s       reg_req,
    output logic [7:0]                        reg_rdata,
    output logic                              reg_rvalid,
    input  wire host_err_pkg::sleep_state_e   sleep_state,
    input  wire logic [39:0]                  sleep_mask_s3,
    input  wire logic [39:0]                  sleep_mask_s45,
    input  wire logic                         legacy_regulator_vid_mode,
    input  wire host_err_pkg::raw_event_s     raw_event,
    input  wire host_err_pkg::throttle_meas_s throttle_meas,
    output logic [39:0]                       status_bank,
    output logic                              host_summary_flag
);
    import host_err_pkg::*;

    localparam int BANK_BITS = 40;

    if (BANK_BITS != 40) begin : g_bank_check
        $error("bank must hold five 8-bit registers");
    end

    ////////////////////////////////////////////////////////////////////////
    logic [39:0] status;
    logic [39:0] raw_vec;
    logic [39:0] sleep_mask;
    logic [39:0] set_vec;
    logic [39:0] clr_vec;
    logic [39:0] next_status;
    logic        asleep;
    logic [7:0]  thr_byte;
    logic        zone_one_limit_flag;
    logic        zone_two_limit_flag;
    logic        zone_three_limit_flag;
    logic        zone_four_limit_flag;
    logic        regulator_one_hot_flag;
    logic        regulator_two_hot_flag;
    logic        diode_1b_fault_flag;
    logic        diode_2b_fault_flag;
    logic        diode_1a_fault_flag;
    logic        diode_2a_fault_flag;
    logic        core_supply_one_mismatch_flag;
    logic        core_supply_two_mismatch_flag;
    logic        fuse_eight_flag;
    logic        fuse_nine_flag;

    ////////////////////////////////////////////////////////////////////////
    // Raw conditions gathered into bank order
    // zone, regulator, diode, fuse and core supply flags
    assign zone_one_limit_flag    = raw_event.zone_limit[0];
    assign zone_two_limit_flag    = raw_event.zone_limit[1];
    assign zone_three_limit_flag  = raw_event.zone_limit[2];
    assign zone_four_limit_flag   = raw_event.zone_limit[3];
    assign regulator_one_hot_flag = raw_event.regulator_one_hot_in;
    assign regulator_two_hot_flag = ~raw_event.regulator_two_hot_in_n;
    assign diode_1b_fault_flag    = raw_event.remote_diode_1b_fault;
    assign diode_2b_fault_flag    = raw_event.remote_diode_2b_fault;
    assign diode_1a_fault_flag    = raw_event.remote_diode_1a_fault;
    assign diode_2a_fault_flag    = raw_event.remote_diode_2a_fault;
    assign fuse_eight_flag = raw_event.fuse_monitor_in_eight
                           & legacy_regulator_vid_mode;
    assign fuse_nine_flag  = raw_event.fuse_monitor_in_nine
                           & legacy_regulator_vid_mode;
    assign core_supply_one_mismatch_flag =
        raw_event.core_supply_one_mismatch;
    assign core_supply_two_mismatch_flag =
        raw_event.core_supply_two_mismatch;

    // throttle any, duty bins, user limit
    always_comb begin
        thr_byte    = 8'h00;
        thr_byte[0] = throttle_meas.cpu1_throttle_in;
        if (throttle_meas.duty_valid) begin
            if (throttle_meas.duty < `HEB_DUTY_EIGHTH) begin
                thr_byte[1] = 1'b1;
            end else if (throttle_meas.duty < `HEB_DUTY_QUARTER) begin
                thr_byte[2] = 1'b1;
            end else if (throttle_meas.duty < `HEB_DUTY_HALF) begin
                thr_byte[3] = 1'b1;
            end else if (throttle_meas.duty < `HEB_DUTY_THREE_Q) begin
                thr_byte[4] = 1'b1;
            end else if (throttle_meas.duty < `HEB_DUTY_FULL) begin
                thr_byte[5] = 1'b1;
            end else begin
                thr_byte[6] = 1'b1;
            end
            thr_byte[7] = throttle_meas.duty > throttle_meas.limit;
        end
    end

    assign raw_vec = {
        thr_byte,
        diode_2a_fault_flag, diode_1a_fault_flag,
        core_supply_two_mismatch_flag, core_supply_one_mismatch_flag,
        fuse_nine_flag, fuse_eight_flag,
        diode_2b_fault_flag, diode_1b_fault_flag,
        raw_event.analog_channel_n,
        2'b00,
        regulator_two_hot_flag, regulator_one_hot_flag,
        zone_four_limit_flag, zone_three_limit_flag,
        zone_two_limit_flag, zone_one_limit_flag
    };

    ////////////////////////////////////////////////////////////////////////
    // Sleep masking
    // stored sleep state selects mask
    always_comb begin
        asleep     = 1'b0;
        sleep_mask = 40'h00_00_00_00_00;
        case (sleep_state)
            SLEEP_S3: begin
                asleep = 1'b1;
                sleep_mask = `HEB_ALWAYS_MASK
                           | (`HEB_OPTION_MASK & sleep_mask_s3);
            end
            SLEEP_S45: begin
                asleep = 1'b1;
                sleep_mask = `HEB_ALWAYS_MASK
                           | (`HEB_OPTION_MASK & sleep_mask_s45);
            end
            default: begin
                asleep     = 1'b0;
                sleep_mask = 40'h00_00_00_00_00;
            end
        endcase
    end

    // masked events cannot set; reserved never set
    assign set_vec = raw_vec & ~sleep_mask & `HEB_IMPL_BITS;

    ////////////////////////////////////////////////////////////////////////
    // Write-one-to-clear decode
    // ones in write data select bits to clear
    always_comb begin
        clr_vec = 40'h00_00_00_00_00;
        if (reg_req.wr) begin
            case (reg_req.addr)
                `HEB_OFS_TEMP_VRD:      clr_vec[7:0]   = reg_req.wdata;
                `HEB_OFS_ANALOG_LOW:    clr_vec[15:8]  = reg_req.wdata;
                `HEB_OFS_ANALOG_HIGH:   clr_vec[23:16] = reg_req.wdata;
                `HEB_OFS_DIODE_FUSE:    clr_vec[31:24] = reg_req.wdata;
                `HEB_OFS_CPU1_THROTTLE: clr_vec[39:32] = reg_req.wdata;
                default:                clr_vec        = 40'h00_00_00_00_00;
            endcase
        end
    end

    assign next_status = ((status & ~clr_vec) | set_vec) & `HEB_IMPL_BITS;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            status <= `HEB_RESET_BANK;
        end else begin
            status <= next_status;
        end
    end

    assign status_bank = status;

    // summary flag, only limit bit of throttle byte
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            host_summary_flag <= 1'b0;
        end else begin
            host_summary_flag <= |(next_status & `HEB_SUMMARY_BITS);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read port, data one cycle after request
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            reg_rdata  <= `HEB_RESET_BYTE;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_req.rd;
            if (reg_req.rd) begin
                case (reg_req.addr)
                    `HEB_OFS_TEMP_VRD:      reg_rdata <= status[7:0];
                    `HEB_OFS_ANALOG_LOW:    reg_rdata <= status[15:8];
                    `HEB_OFS_ANALOG_HIGH:   reg_rdata <= status[23:16];
                    `HEB_OFS_DIODE_FUSE:    reg_rdata <= status[31:24];
                    `HEB_OFS_CPU1_THROTTLE: reg_rdata <= status[39:32];
                    default:                reg_rdata <= `HEB_RESET_BYTE;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    property p_clear_one;
        @(posedge clk) disable iff (!rst_n)
        (reg_req.wr && reg_req.addr == `HEB_OFS_TEMP_VRD
            && reg_req.wdata[`HEB_BIT_ZONE_THREE]
            && !set_vec[`HEB_BIT_ZONE_THREE])
        |=> !status[`HEB_BIT_ZONE_THREE];
    endproperty
    a_clear_one: assert property (p_clear_one)
        else $error("write of one did not clear bit");

    property p_no_self_clear;
        @(posedge clk) disable iff (!rst_n)
        $past(rst_n) && (($past(status) & ~status) != 40'h0)
        |-> (($past(status) & ~status & ~$past(clr_vec)) == 40'h0);
    endproperty
    a_no_self_clear: assert property (p_no_self_clear)
        else $error("status bit fell without a clear write");

    property p_clear_refused;
        @(posedge clk) disable iff (!rst_n)
        ((clr_vec & set_vec) != 40'h0)
        |=> ((status & $past(clr_vec & set_vec))
             == $past(clr_vec & set_vec));
    endproperty
    a_clear_refused: assert property (p_clear_refused)
        else $error("clear took effect while condition present");

    property p_masked_quiet;
        @(posedge clk) disable iff (!rst_n)
        (((raw_vec & sleep_mask & ~status) != 40'h0) && clr_vec == 40'h0)
        |=> ((status & $past(raw_vec & sleep_mask & ~status)) == 40'h0);
    endproperty
    a_masked_quiet: assert property (p_masked_quiet)
        else $error("masked event set a status bit");

    property p_never_masked;
        @(posedge clk) disable iff (!rst_n)
        (raw_vec[`HEB_BIT_ZONE_THREE] || raw_vec[`HEB_BIT_CH16])
        |=> (status[`HEB_BIT_ZONE_THREE]
                || !$past(raw_vec[`HEB_BIT_ZONE_THREE]))
            && (status[`HEB_BIT_CH16] || !$past(raw_vec[`HEB_BIT_CH16]));
    endproperty
    a_never_masked: assert property (p_never_masked)
        else $error("unmaskable event failed to set");

    property p_regulator_asleep;
        @(posedge clk) disable iff (!rst_n)
        (asleep && regulator_one_hot_flag
            && !status[`HEB_BIT_REG_ONE_HOT])
        |=> !status[`HEB_BIT_REG_ONE_HOT];
    endproperty
    a_regulator_asleep: assert property (p_regulator_asleep)
        else $error("regulator hot set while asleep");

    property p_optional_unmasked;
        @(posedge clk) disable iff (!rst_n)
        (sleep_state == SLEEP_S3 && !sleep_mask_s3[`HEB_BIT_ZONE_ONE]
            && zone_one_limit_flag)
        |=> status[`HEB_BIT_ZONE_ONE];
    endproperty
    a_optional_unmasked: assert property (p_optional_unmasked)
        else $error("optional event lost with mask clear");

    property p_reserved_zero;
        @(posedge clk) disable iff (!rst_n)
        reg_req.rd && reg_req.addr == `HEB_OFS_TEMP_VRD
        |=> reg_rvalid && reg_rdata[7:6] == 2'b00
            && reg_rdata == $past(status[7:0]);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved bits read nonzero");

    property p_fuse_gated;
        @(posedge clk) disable iff (!rst_n)
        (!legacy_regulator_vid_mode && !status[`HEB_BIT_FUSE_EIGHT])
        |=> !status[`HEB_BIT_FUSE_EIGHT];
    endproperty
    a_fuse_gated: assert property (p_fuse_gated)
        else $error("fuse flag set outside legacy mode");

    property p_full_duty;
        @(posedge clk) disable iff (!rst_n)
        (!asleep && throttle_meas.duty_valid
            && throttle_meas.duty == `HEB_DUTY_FULL)
        |=> status[`HEB_BIT_THR_FULL];
    endproperty
    a_full_duty: assert property (p_full_duty)
        else $error("full throttle bin not set");

    property p_limit;
        @(posedge clk) disable iff (!rst_n)
        (!asleep && throttle_meas.duty_valid
            && throttle_meas.duty > throttle_meas.limit)
        |=> status[`HEB_BIT_THR_LIMIT] ##1 host_summary_flag;
    endproperty
    a_limit: assert property (p_limit)
        else $error("limit flag or summary missing");

    property p_summary;
        @(posedge clk) disable iff (!rst_n)
        host_summary_flag == |(status & `HEB_SUMMARY_BITS);
    endproperty
    a_summary: assert property (p_summary)
        else $error("summary flag disagrees with bank");

    property p_reset_zero;
        @(posedge clk)
        !rst_n |=> status == 40'h0 && !host_summary_flag;
    endproperty
    a_reset_zero: assert property (p_reset_zero)
        else $error("bank not zero after reset");

endmodule // host_error_status_bank
